// File: hdl/but_pkg.sv
package but_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTL0  = 8'h00;
  localparam logic [7:0] OFS_CTL1  = 8'h04;
  localparam logic [7:0] OFS_INTEN = 8'h0C;
  localparam logic [7:0] OFS_INTF  = 8'h10;
  localparam logic [7:0] OFS_SWEVG = 8'h14;
  localparam logic [7:0] OFS_CNTL  = 8'h24;
  localparam logic [7:0] OFS_PSC   = 8'h28;
  localparam logic [7:0] OFS_CARL  = 8'h2C;
  localparam logic [7:0] OFS_CARH  = 8'h30;
  localparam logic [7:0] OFS_DBG   = 8'h34;
  localparam logic [7:0] OFS_CNTH  = 8'hD0;
  // control field positions
  localparam int CEN_BIT   = 0;
  localparam int UPDATE_DISABLE_BIT = 1;
  localparam int UPS_BIT   = 2;
  localparam int SPM_BIT   = 3;
  localparam int RELOAD_SHADOW_ENABLE_BIT  = 7;
  localparam int FBE_BIT   = 11;
  localparam int UPDATE_DMA_ENABLE_BIT = 8;
  localparam int BKP_BIT   = 31;
  localparam logic [11:0] CTL0_MASK = 12'h88F;
  // reset values
  localparam logic [31:0] CAR_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] ZERO32  = 32'h0000_0000;
  localparam logic [15:0] PSC_RST = 16'h0000;
  // trigger output source select
  typedef enum logic [2:0] {
    TRG_RESET  = 3'h0,
    TRG_ENABLE = 3'h1,
    TRG_UPDATE = 3'h2
  } but_trg_t;
  typedef struct packed {
    logic        flag_backup_enable;
    logic        reload_shadow_enable;
    logic        single_pulse_select;
    logic        update_source_select;
    logic        update_disable;
    logic        counter_enable;
  } but_ctl_t;
endpackage : but_pkg

// File: hdl/but_presc.sv
module but_presc
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        run,
  input  wire logic        clr,
  input  wire logic [15:0] div,
  output logic             tick
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        tick_nxt;

  // counts timer clocks; tick once every div+1 clocks
  always_comb
  begin
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (clr)
      cnt_nxt = 16'h0000;
    else if (run)
    begin
      if (cnt_r >= div)
      begin
        cnt_nxt  = 16'h0000;
        tick_nxt = 1'b1;
      end
      else
        cnt_nxt = cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= 16'h0000;
      tick  <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tick  <= tick_nxt;
    end
  end
endmodule : but_presc

// File: hdl/but_timer.sv
// Chosen here: the APB interface to the registers.
module but_timer #(
  parameter bit WIDE = 1'b0
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cpu_halted,
  output logic             irq,
  output logic             dma_req,
  output logic             trigger_output
);
  localparam int CW = WIDE ? 64 : 32;

  but_pkg::but_ctl_t ctl_r, ctl_nxt;
  logic [2:0]    trg_sel_r, trg_sel_nxt;
  logic          update_interrupt_enable_r, update_interrupt_enable_nxt;
  logic          update_dma_enable_r, update_dma_enable_nxt;
  logic          flag_r, flag_nxt;
  logic          hold_r, hold_nxt;
  logic [15:0]   psc_pre_r, psc_pre_nxt;
  logic [15:0]   psc_act_r, psc_act_nxt;
  logic [63:0]   car_pre_r, car_pre_nxt;
  logic [63:0]   car_act_r, car_act_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [31:0]   prdata_nxt;
  logic          pready_nxt, pslverr_nxt;
  logic          irq_nxt, dma_nxt, trg_nxt;
  logic          wr, rd, ug, run, tick, ovf, upd, upd_req;
  logic [63:0]   car_use;

  function automatic logic hit(input logic [7:0] a);
    hit = (a == but_pkg::OFS_CTL0) || (a == but_pkg::OFS_CTL1) ||
          (a == but_pkg::OFS_INTEN) || (a == but_pkg::OFS_INTF) ||
          (a == but_pkg::OFS_SWEVG) || (a == but_pkg::OFS_CNTL) ||
          (a == but_pkg::OFS_PSC) || (a == but_pkg::OFS_CARL) ||
          (a == but_pkg::OFS_DBG) ||
          (WIDE && ((a == but_pkg::OFS_CARH) || (a == but_pkg::OFS_CNTH)));
  endfunction : hit

  function automatic logic [31:0] with_bkp(input logic [31:0] w);
    with_bkp = w;
    with_bkp[but_pkg::BKP_BIT] = ctl_r.flag_backup_enable & flag_r;
  endfunction : with_bkp

  // bus handshake: one wait state in each access phase (pready registered)
  assign wr  = psel & penable & pwrite & pready;
  assign rd  = psel & penable & ~pwrite & ~pready;
  assign ug  = wr && paddr == but_pkg::OFS_SWEVG && pwdata[0];
  assign run = ctl_r.counter_enable & ~(cpu_halted & hold_r);

  but_presc u_presc
  (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (run),
    .clr     (ug),
    .div     (psc_act_r),
    .tick    (tick)
  );

  assign car_use = ctl_r.reload_shadow_enable ? car_act_r : car_pre_r;
  assign ovf     = tick && run && (64'(cnt_r) >= car_use);
  assign upd     = (ovf || ug) && !ctl_r.update_disable;
  assign upd_req = ctl_r.update_source_select ? (ovf && upd) : upd;

  always_comb
  begin
    ctl_nxt     = ctl_r;
    trg_sel_nxt = trg_sel_r;
    update_interrupt_enable_nxt    = update_interrupt_enable_r;
    update_dma_enable_nxt   = update_dma_enable_r;
    hold_nxt    = hold_r;
    psc_pre_nxt = psc_pre_r;
    car_pre_nxt = car_pre_r;
    psc_act_nxt = psc_act_r;
    car_act_nxt = car_act_r;
    cnt_nxt     = cnt_r;
    flag_nxt    = flag_r;
    prdata_nxt  = but_pkg::ZERO32;
    pready_nxt  = psel & penable & ~pready;
    pslverr_nxt = psel & penable & ~pready & ~hit(paddr);
    if (wr)
    begin
      case (paddr)
        but_pkg::OFS_CTL0:
        begin
          ctl_nxt.flag_backup_enable   = pwdata[but_pkg::FBE_BIT];
          ctl_nxt.reload_shadow_enable = pwdata[but_pkg::RELOAD_SHADOW_ENABLE_BIT];
          ctl_nxt.single_pulse_select  = pwdata[but_pkg::SPM_BIT];
          ctl_nxt.update_source_select = pwdata[but_pkg::UPS_BIT];
          ctl_nxt.update_disable       = pwdata[but_pkg::UPDATE_DISABLE_BIT];
          ctl_nxt.counter_enable       = pwdata[but_pkg::CEN_BIT];
        end
        but_pkg::OFS_CTL1:  trg_sel_nxt = pwdata[6:4];
        but_pkg::OFS_INTEN:
        begin
          update_interrupt_enable_nxt  = pwdata[0];
          update_dma_enable_nxt = pwdata[but_pkg::UPDATE_DMA_ENABLE_BIT];
        end
        but_pkg::OFS_INTF:  flag_nxt = flag_r & pwdata[0];
        but_pkg::OFS_DBG:   hold_nxt = pwdata[0];
        but_pkg::OFS_PSC:   psc_pre_nxt = pwdata[15:0];
        but_pkg::OFS_CARL:  car_pre_nxt[31:0] = pwdata;
        but_pkg::OFS_CARH:  car_pre_nxt[63:32] = pwdata;
        but_pkg::OFS_CNTL:
          if (WIDE)
            cnt_nxt[31:0] = pwdata;
          else
            cnt_nxt[30:0] = pwdata[30:0] | 31'(0);
        but_pkg::OFS_CNTH:
          if (WIDE)
            cnt_nxt[CW-1:CW-32] = pwdata;
        default: ;
      endcase
      if (!WIDE && paddr == but_pkg::OFS_CNTL && !ctl_r.flag_backup_enable)
        cnt_nxt[31] = pwdata[31];
      if (WIDE && paddr == but_pkg::OFS_CNTH && ctl_r.flag_backup_enable)
        cnt_nxt[CW-1] = cnt_r[CW-1];
    end
    if (rd)
    begin
      case (paddr)
        but_pkg::OFS_CTL0:  prdata_nxt = 32'(ctl_r.flag_backup_enable) << but_pkg::FBE_BIT
                                       | 32'(ctl_r.reload_shadow_enable) << but_pkg::RELOAD_SHADOW_ENABLE_BIT
                                       | 32'(ctl_r.single_pulse_select) << but_pkg::SPM_BIT
                                       | 32'(ctl_r.update_source_select) << but_pkg::UPS_BIT
                                       | 32'(ctl_r.update_disable) << but_pkg::UPDATE_DISABLE_BIT
                                       | 32'(ctl_r.counter_enable);
        but_pkg::OFS_CTL1:  prdata_nxt = {25'h0, trg_sel_r, 4'h0};
        but_pkg::OFS_INTEN: prdata_nxt = {23'h0, update_dma_enable_r, 7'h00, update_interrupt_enable_r};
        but_pkg::OFS_INTF:  prdata_nxt = {31'h0, flag_r};
        but_pkg::OFS_DBG:   prdata_nxt = {31'h0, hold_r};
        but_pkg::OFS_PSC:   prdata_nxt = {16'h0000, psc_pre_r};
        but_pkg::OFS_CARL:  prdata_nxt = car_pre_r[31:0];
        but_pkg::OFS_CARH:  prdata_nxt = WIDE ? car_pre_r[63:32] : but_pkg::ZERO32;
        but_pkg::OFS_CNTL:
          prdata_nxt = WIDE ? 32'(cnt_r) : with_bkp({1'b0, cnt_r[30:0]});
        but_pkg::OFS_CNTH:
          prdata_nxt = WIDE ? with_bkp({1'b0, 31'(64'(cnt_r) >> 32)}) : but_pkg::ZERO32;
        default:            prdata_nxt = but_pkg::ZERO32;
      endcase
    end
    if (ug)
      cnt_nxt = '0;
    else if (ovf)
      cnt_nxt = '0;
    else if (tick && run)
      cnt_nxt = cnt_r + 1'b1;
    if (upd)
    begin
      psc_act_nxt = psc_pre_nxt;
      car_act_nxt = car_pre_nxt;
      if (ctl_r.single_pulse_select)
        ctl_nxt.counter_enable = 1'b0;
    end
    if (upd_req)
      flag_nxt = 1'b1;
    irq_nxt = flag_nxt & update_interrupt_enable_nxt;
    dma_nxt = upd_req & update_dma_enable_r;
    case (but_trg_sel_cast(trg_sel_r))
      but_pkg::TRG_RESET:  trg_nxt = ug;
      but_pkg::TRG_ENABLE: trg_nxt = ctl_nxt.counter_enable;
      but_pkg::TRG_UPDATE: trg_nxt = upd;
      default:             trg_nxt = 1'b0;
    endcase
  end

  function automatic but_pkg::but_trg_t but_trg_sel_cast(input logic [2:0] s);
    but_trg_sel_cast = but_pkg::but_trg_t'(s);
  endfunction : but_trg_sel_cast

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_r          <= '0;
      trg_sel_r      <= 3'h0;
      update_interrupt_enable_r         <= 1'b0;
      update_dma_enable_r        <= 1'b0;
      flag_r         <= 1'b0;
      hold_r         <= 1'b0;
      psc_pre_r      <= but_pkg::PSC_RST;
      psc_act_r      <= but_pkg::PSC_RST;
      car_pre_r      <= {2{but_pkg::CAR_RST}};
      car_act_r      <= {2{but_pkg::CAR_RST}};
      cnt_r          <= '0;
      prdata         <= but_pkg::ZERO32;
      pready         <= 1'b0;
      pslverr        <= 1'b0;
      irq            <= 1'b0;
      dma_req        <= 1'b0;
      trigger_output <= 1'b0;
    end
    else
    begin
      ctl_r          <= ctl_nxt;
      trg_sel_r      <= trg_sel_nxt;
      update_interrupt_enable_r         <= update_interrupt_enable_nxt;
      update_dma_enable_r        <= update_dma_enable_nxt;
      flag_r         <= flag_nxt;
      hold_r         <= hold_nxt;
      psc_pre_r      <= psc_pre_nxt;
      psc_act_r      <= psc_act_nxt;
      car_pre_r      <= WIDE ? car_pre_nxt : {32'h0000_0000, car_pre_nxt[31:0]};
      car_act_r      <= WIDE ? car_act_nxt : {32'h0000_0000, car_act_nxt[31:0]};
      cnt_r          <= cnt_nxt;
      prdata         <= prdata_nxt;
      pready         <= pready_nxt;
      pslverr        <= pslverr_nxt;
      irq            <= irq_nxt;
      dma_req        <= dma_nxt;
      trigger_output <= trg_nxt;
    end
  end

  AST_UG_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    ug |=> (cnt_r == '0)) else $error("counter not cleared by update generate");
  AST_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
    upd_req |=> flag_r) else $error("update flag not set");
  AST_UPDATE_DISABLE: assert property (@(posedge pclk) disable iff (!presetn)
    ctl_r.update_disable |-> !upd) else $error("update while disabled");
  AST_SPM_STOP: assert property (@(posedge pclk) disable iff (!presetn)
    (upd && ctl_r.single_pulse_select) |=> !ctl_r.counter_enable)
    else $error("single pulse did not stop");
  AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (cpu_halted && hold_r && !ug && !wr) |=> $stable(cnt_r))
    else $error("counter moved in debug hold");
  AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    irq == (flag_r & update_interrupt_enable_r)) else $error("irq mismatch");
  AST_UPS: assert property (@(posedge pclk) disable iff (!presetn)
    (ctl_r.update_source_select && !ovf) |-> !upd_req)
    else $error("request from non-overflow source");
  AST_RELOAD: assert property (@(posedge pclk) disable iff (!presetn)
    upd |=> (psc_act_r == $past(psc_pre_nxt, 1)))
    else $error("prescaler not loaded on update");
  AST_DMA_ON: assert property (@(posedge pclk) disable iff (!presetn)
    (upd_req && update_dma_enable_r) |=> dma_req)
    else $error("dma request missing");
  AST_DMA_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !update_dma_enable_r |=> !dma_req)
    else $error("dma request while disabled");
  AST_OVF_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
    (ovf && !ug) |=> (cnt_r == '0))
    else $error("counter did not restart after reload value");
  AST_COUNT_UP: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && run && !ovf && !ug && !wr) |=> (cnt_r == $past(cnt_r) + 1'b1))
    else $error("counter did not step up");
  AST_NO_RUN: assert property (@(posedge pclk) disable iff (!presetn)
    (!run && !ug && !wr) |=> $stable(cnt_r))
    else $error("counter moved while stopped");
  AST_CAR_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    upd |=> (car_act_r[31:0] == 32'($past(car_pre_nxt))))
    else $error("reload not loaded on update");
  AST_PSC_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !upd |=> (psc_act_r == $past(psc_act_r)))
    else $error("prescaler changed without update");
  AST_FLAG_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == but_pkg::OFS_INTF && !pwdata[0] && !upd_req) |=> !flag_r)
    else $error("update flag not cleared");
  AST_BKP_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && !WIDE && paddr == but_pkg::OFS_CNTL && !ctl_r.flag_backup_enable) |=> !prdata[31])
    else $error("backup bit set while backup off");
  AST_BKP_ON: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && !WIDE && paddr == but_pkg::OFS_CNTL && ctl_r.flag_backup_enable && flag_r)
    |=> prdata[31]) else $error("backup bit not mirrored");
  AST_IRQ_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !update_interrupt_enable_nxt |=> !irq)
    else $error("irq while interrupt disabled");
  AST_TRG_UPD: assert property (@(posedge pclk) disable iff (!presetn)
    (trg_sel_r == 3'h2 && upd) |=> trigger_output)
    else $error("trigger missing on update");
endmodule : but_timer

// File: bench/but_sink.sv
module but_sink
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic dma_req,
  input  wire logic trigger_output,
  output int        dma_cnt,
  output int        trg_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic trg_d;
  // dma controller and dac trigger input: count request pulses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dma_cnt <= 0;
      trg_cnt <= 0;
      trg_d   <= 1'b0;
    end
    else
    begin
      trg_d <= trigger_output;
      if (dma_req)
        dma_cnt <= dma_cnt + 1;
      if (trigger_output && !trg_d)
        trg_cnt <= trg_cnt + 1;
    end
  end
endmodule : but_sink

// File: bench/but_timer_test.sv
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin err_total++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module but_timer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cpu_halted = 1'b0;
  logic        irq;
  logic        dma_req;
  logic        trigger_output;
  logic [31:0] rdata;
  logic        rerr;
  int          dma_cnt;
  int          trg_cnt;
  int          err_total = 0;
  int          checks = 0;
  always #5 pclk = ~pclk;
  but_timer #(.WIDE(1'b0)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_halted(cpu_halted), .irq(irq),
    .dma_req(dma_req), .trigger_output(trigger_output));
  but_sink sink_u (.pclk(pclk), .presetn(presetn), .dma_req(dma_req),
    .trigger_output(trigger_output), .dma_cnt(dma_cnt), .trg_cnt(trg_cnt));
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      err_total++;
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic t_reset;
    rd(but_pkg::OFS_CTL0); `CHK("ctl0", 32'h0, rdata)
    rd(but_pkg::OFS_CARL); `CHK("car", 32'hFFFF_FFFF, rdata)
    rd(8'h40); `CHK("unmapped", 1'b1, rerr)
  endtask : t_reset
  task automatic t_overflow;
    int n;
    n = 0;
    wr(but_pkg::OFS_INTEN, 32'h1);
    wr(but_pkg::OFS_CARL, 32'h4);
    wr(but_pkg::OFS_CTL0, 32'h1);
    while (irq !== 1'b1 && n < 60)
    begin
      @(posedge pclk);
      n++;
    end
    `CHK("irq", 1'b1, irq)
    rd(but_pkg::OFS_CNTL); `CHK("cnt_in_range", 1'b1, rdata <= 32'h4)
    wr(but_pkg::OFS_CTL0, 32'h0);
    wr(but_pkg::OFS_INTF, 32'h0);
    rd(but_pkg::OFS_INTF); `CHK("flag_clr", 32'h0, rdata)
  endtask : t_overflow
  task automatic t_swupd;
    int d0;
    wr(but_pkg::OFS_INTEN, 32'h100);
    wr(but_pkg::OFS_CNTL, 32'h123);
    d0 = dma_cnt;
    wr(but_pkg::OFS_SWEVG, 32'h1);
    rd(but_pkg::OFS_CNTL); `CHK("ug_cnt", 32'h0, rdata)
    rd(but_pkg::OFS_INTF); `CHK("ug_flag", 32'h1, rdata)
    `CHK("dma", d0 + 1, dma_cnt)
    wr(but_pkg::OFS_INTF, 32'h0);
    wr(but_pkg::OFS_CTL0, 32'h4);
    wr(but_pkg::OFS_SWEVG, 32'h1);
    rd(but_pkg::OFS_INTF); `CHK("ups_flag", 32'h0, rdata)
    `CHK("ups_dma", d0 + 1, dma_cnt)
    wr(but_pkg::OFS_CTL0, 32'h2);
    wr(but_pkg::OFS_CNTL, 32'h5);
    wr(but_pkg::OFS_SWEVG, 32'h1);
    rd(but_pkg::OFS_CNTL); `CHK("dis_cnt", 32'h0, rdata)
    rd(but_pkg::OFS_INTF); `CHK("dis_flag", 32'h0, rdata)
  endtask : t_swupd
  task automatic t_trig;
    int t0;
    wr(but_pkg::OFS_CTL0, 32'h0);
    wr(but_pkg::OFS_CTL1, 32'h20);
    t0 = trg_cnt;
    wr(but_pkg::OFS_SWEVG, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK("trg_upd", t0 + 1, trg_cnt)
    wr(but_pkg::OFS_CTL1, 32'h10);
    wr(but_pkg::OFS_CTL0, 32'h1);
    @(posedge pclk);
    `CHK("trg_en", 1'b1, trigger_output)
    wr(but_pkg::OFS_CTL0, 32'h0);
    wr(but_pkg::OFS_INTF, 32'h0);
  endtask : t_trig
  task automatic t_single;
    wr(but_pkg::OFS_CARL, 32'h3);
    wr(but_pkg::OFS_CNTL, 32'h0);
    wr(but_pkg::OFS_CTL0, 32'h9);
    repeat (20) @(posedge pclk);
    rd(but_pkg::OFS_CTL0); `CHK("spm_ctl", 32'h8, rdata)
    rd(but_pkg::OFS_CNTL); `CHK("spm_cnt", 32'h0, rdata)
  endtask : t_single
  task automatic t_backup;
    wr(but_pkg::OFS_CTL0, 32'h800);
    rd(but_pkg::OFS_CNTL); `CHK("bkp_on", 1'b1, rdata[31])
    wr(but_pkg::OFS_INTF, 32'h0);
    rd(but_pkg::OFS_CNTL); `CHK("bkp_clr", 1'b0, rdata[31])
    wr(but_pkg::OFS_SWEVG, 32'h1);
    wr(but_pkg::OFS_CTL0, 32'h0);
    rd(but_pkg::OFS_CNTL); `CHK("bkp_off", 1'b0, rdata[31])
  endtask : t_backup
  task automatic t_hold;
    logic [31:0] a;
    wr(but_pkg::OFS_DBG, 32'h1);
    cpu_halted <= 1'b1;
    wr(but_pkg::OFS_CARL, 32'hFFFF_FFFF);
    wr(but_pkg::OFS_CNTL, 32'h0);
    wr(but_pkg::OFS_CTL0, 32'h1);
    rd(but_pkg::OFS_CNTL);
    a = rdata;
    rd(but_pkg::OFS_CNTL); `CHK("hold", a, rdata)
    cpu_halted <= 1'b0;
    rd(but_pkg::OFS_CNTL); `CHK("resume", 1'b1, rdata > a)
    wr(but_pkg::OFS_CTL0, 32'h0);
    wr(but_pkg::OFS_DBG, 32'h0);
  endtask : t_hold
  task automatic t_presc;
    wr(but_pkg::OFS_PSC, 32'h9);
    wr(but_pkg::OFS_CNTL, 32'h0);
    wr(but_pkg::OFS_CTL0, 32'h1);
    wr(but_pkg::OFS_CTL0, 32'h0);
    rd(but_pkg::OFS_CNTL); `CHK("psc_old", 1'b1, rdata >= 32'h3)
    wr(but_pkg::OFS_SWEVG, 32'h1);
    wr(but_pkg::OFS_CTL0, 32'h1);
    repeat (60) @(posedge pclk);
    wr(but_pkg::OFS_CTL0, 32'h0);
    rd(but_pkg::OFS_CNTL);
    `CHK("psc_new", 1'b1, rdata >= 32'h6 && rdata <= 32'h7)
  endtask : t_presc
  task automatic t_shadow;
    int t0;
    wr(but_pkg::OFS_CTL1, 32'h0);
    wr(but_pkg::OFS_PSC, 32'h0);
    wr(but_pkg::OFS_CARL, 32'hFFFF_FFFF);
    t0 = trg_cnt;
    wr(but_pkg::OFS_SWEVG, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK("trg_rst", t0 + 1, trg_cnt)
    wr(but_pkg::OFS_CARL, 32'h2);
    wr(but_pkg::OFS_CTL0, 32'h81);
    repeat (20) @(posedge pclk);
    wr(but_pkg::OFS_CTL0, 32'h0);
    rd(but_pkg::OFS_CNTL); `CHK("shadow_old", 1'b1, rdata > 32'h2)
    wr(but_pkg::OFS_SWEVG, 32'h1);
    wr(but_pkg::OFS_CTL0, 32'h81);
    repeat (20) @(posedge pclk);
    wr(but_pkg::OFS_CTL0, 32'h0);
    rd(but_pkg::OFS_CNTL); `CHK("shadow_new", 1'b1, rdata <= 32'h2)
  endtask : t_shadow
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (20000) @(posedge pclk);
    err_total++;
    print_verdict();
  end
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_overflow();
    t_swupd();
    t_trig();
    t_single();
    t_backup();
    t_hold();
    t_presc();
    t_shadow();
    print_verdict();
  end
endmodule : but_timer_test
